// File: bench/opd_decoder_chk.sv
// concurrent checks on the opcode decoder ports
`timescale 1ns/1ps
module opd_decoder_chk (
	input wire logic                clk_sys_i,
	input wire logic                resetn_i,
	input wire logic                op_valid_i,
	input wire logic [7:0]          opcode_i,
	input wire logic [7:0]          flags_i,
	input wire logic                dec_valid_o,
	input wire opd_pkg::opd_class_t class_o,
	input wire logic [2:0]          dest_field_o,
	input wire logic [2:0]          src_field_o,
	input wire logic [1:0]          pair_o,
	input wire opd_pkg::opd_cond_t  cond_o,
	input wire opd_pkg::opd_alu_t   alu_o,
	input wire logic                accumulator_flags_word_o,
	input wire logic                cond_true_o,
	input wire logic [4:0]          cycles_o,
	input wire logic                dest_mem_o,
	input wire logic                src_mem_o
);
	import opd_pkg::*;
	// ********************************
	// last taken opcode
	// ********************************
	logic       tk_q;
	logic [7:0] op_q;
	logic [7:0] fl_q;
	always_ff @(posedge clk_sys_i) begin
		tk_q <= op_valid_i & resetn_i;
		op_q <= opcode_i;
		fl_q <= flags_i;
	end
	function automatic logic hit(input logic [2:0] cc, input logic [7:0] f);
		logic b;
		b = cc[2] ? (cc[1] ? f[7] : f[2]) : (cc[1] ? f[0] : f[6]);
		return b == cc[0];
	endfunction
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// ********************************
	// assertions
	// ********************************
	valid_pulse_a: assert property (dec_valid_o == tk_q)
		else $error("decode strobe not one cycle after opcode");
	halt_wins_a: assert property (
		tk_q && op_q == 8'h76 |-> class_o == OPD_CLS_HALT_OP && cycles_o == 5'h05)
		else $error("halt opcode misdecoded");
	move_cyc_a: assert property (
		tk_q && op_q[7:6] == 2'h1 && op_q != 8'h76 |-> dest_field_o == op_q[5:3] && src_field_o == op_q[2:0]
		&& dest_mem_o == (op_q[5:3] == 3'h6) && src_mem_o == (op_q[2:0] == 3'h6)
		&& cycles_o == ((op_q[5:3] == 3'h6 || op_q[2:0] == 3'h6) ? 5'h07 : 5'h04))
		else $error("move fields or cycles wrong");
	alu_reg_a: assert property (
		tk_q && op_q[7:6] == 2'h2 |-> alu_o == opd_alu_t'(op_q[5:3]) && src_mem_o == (op_q[2:0] == 3'h6)
		&& cycles_o == (op_q[2:0] == 3'h6 ? 5'h07 : 5'h04))
		else $error("alu register or memory form wrong");
	alu_imm_a: assert property (
		tk_q && op_q[7:6] == 2'h3 && op_q[2:0] == 3'h6 |-> class_o == OPD_CLS_ALU_IMM
		&& alu_o == opd_alu_t'(op_q[5:3]) && cycles_o == 5'h07)
		else $error("alu immediate form wrong");
	cond_eval_a: assert property (
		tk_q |-> cond_true_o == hit(op_q[5:3], fl_q) && cond_o == opd_cond_t'(op_q[5:3]))
		else $error("condition select or outcome wrong");
	branch_cyc_a: assert property (
		tk_q && op_q[7:6] == 2'h3 && op_q[2:0] inside {3'h0, 3'h2, 3'h4} |-> cycles_o == (op_q[2]
		? (cond_true_o ? 5'h12 : 5'h09) : op_q[1] ? (cond_true_o ? 5'h0a : 5'h07) : (cond_true_o ? 5'h0c : 5'h06)))
		else $error("conditional transfer cycles wrong");
	pair_fld_a: assert property (
		tk_q && op_q[7:6] == 2'h0 && op_q[3:0] inside {4'h1, 4'h3, 4'h9, 4'hb}
		|-> pair_o == op_q[5:4] && cycles_o == (op_q[1] ? 5'h06 : 5'h0a))
		else $error("pair field or cycles wrong");
	stack_pair_a: assert property (
		tk_q && op_q[7:6] == 2'h3 && op_q[3:0] inside {4'h1, 4'h5}
		|-> accumulator_flags_word_o == (op_q[5:4] == 2'h3) && cycles_o == (op_q[2] ? 5'h0c : 5'h0a))
		else $error("push or pop decode wrong");
	fixed_cyc_a: assert property (
		tk_q && op_q inside {8'he3, 8'h07, 8'h0f, 8'h17, 8'h1f} |-> cycles_o == (op_q[7] ? 5'h10 : 5'h04))
		else $error("swap or rotate cycles wrong");
	hold_quiet_a: assert property (!tk_q && $past(resetn_i) |-> $stable(class_o) && $stable(cycles_o))
		else $error("fields changed without opcode");
endmodule
bind opd_decoder opd_decoder_chk u_chk (.clk_sys_i, .resetn_i, .op_valid_i, .opcode_i, .flags_i, .dec_valid_o,
	.class_o, .dest_field_o, .src_field_o, .pair_o, .cond_o, .alu_o, .accumulator_flags_word_o, .cond_true_o,
	.cycles_o, .dest_mem_o, .src_mem_o);

// File: bench/opd_seq_model.sv
// sequencer stand-in that spends the cycle budget of each decoded opcode
`timescale 1ns/1ps
module opd_seq_model (
	input  wire logic       clk_sys_i,
	input  wire logic       resetn_i,
	input  wire logic       dec_valid_i,
	input  wire logic [4:0] cycles_i,
	output int              total_o
);
	// ********************************
	// budget accumulator
	// ********************************
	// takes each strobe on the edge after it rises; a missed or doubled strobe skews the sum
	always @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			total_o <= 0;
		end else if (dec_valid_i) begin
			total_o <= total_o + int'(cycles_i);
		end
	end
endmodule

// File: bench/test_opd_decoder.sv
// self-checking bench for the opcode decoder
`timescale 1ns/1ps
module test_opd_decoder;
	import opd_pkg::*;
	logic       clk_sys_i, resetn_i, op_valid_i, dec_valid_o, cond_true_o, dest_mem_o, src_mem_o;
	logic       accumulator_flags_word_o;
	logic [7:0] opcode_i, flags_i;
	logic [2:0] dest_field_o, src_field_o;
	logic [1:0] pair_o;
	logic [4:0] cycles_o;
	opd_class_t class_o;
	opd_cond_t  cond_o;
	opd_alu_t   alu_o;
	int         bad_count, checks_done, total, exp_total;

	opd_decoder dut (.clk_sys_i, .resetn_i, .op_valid_i, .opcode_i, .flags_i, .dec_valid_o, .class_o,
		.dest_field_o, .src_field_o, .pair_o, .cond_o, .alu_o, .accumulator_flags_word_o, .cond_true_o,
		.cycles_o, .dest_mem_o, .src_mem_o);
	opd_seq_model u_seq (.clk_sys_i, .resetn_i, .dec_valid_i(dec_valid_o), .cycles_i(cycles_o), .total_o(total));

	// ********************************
	// shared tasks
	// ********************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic go(input logic [7:0] op, input logic [7:0] fl);
		@(posedge clk_sys_i);
		op_valid_i <= 1'b1;
		opcode_i <= op;
		flags_i <= fl;
		@(posedge clk_sys_i);
		op_valid_i <= 1'b0;
		#1;
	endtask
	task automatic dec(input logic [7:0] op, input logic [7:0] fl, input opd_class_t cls, input logic [4:0] cyc);
		go(op, fl);
		exp_total += int'(cyc);
		chk("valid", 32'(dec_valid_o), 32'h1);
		chk("class", 32'(class_o), 32'(cls));
		chk("cycles", 32'(cycles_o), 32'(cyc));
	endtask
	task automatic t_clear();
		chk("valid", 32'(dec_valid_o), 32'h0);
		chk("class", 32'(class_o), 32'(OPD_CLS_NONE));
		chk("cycles", 32'(cycles_o), 32'h0);
		chk("afw", 32'(accumulator_flags_word_o), 32'h0);
	endtask
	// ********************************
	// scenarios
	// ********************************
	task automatic t_move();
		opd_class_t c;
		logic [4:0] n;
		for (int i = 0; i < 64; i++) begin
			c = OPD_CLS_COPY_OP;
			n = 5'h04;
			if (i[5:3] == 3'h6) c = OPD_CLS_STORE_MEM;
			if (i[2:0] == 3'h6) c = OPD_CLS_LOAD_MEM;
			if (c != OPD_CLS_COPY_OP) n = 5'h07;
			if (i == 6'h36) c = OPD_CLS_HALT_OP;
			if (i == 6'h36) n = 5'h05;
			dec({2'h1, i[5:0]}, 8'h00, c, n);
			chk("dest", 32'(dest_field_o), 32'(i[5:3]));
			chk("src", 32'(src_field_o), 32'(i[2:0]));
			chk("dmem", 32'(dest_mem_o), 32'(c == OPD_CLS_STORE_MEM));
		end
	endtask
	task automatic t_alu();
		for (int i = 0; i < 64; i++) begin
			dec({2'h2, i[5:0]}, 8'h00, i[2:0] == 3'h6 ? OPD_CLS_ALU_MEM : OPD_CLS_ALU_REG,
				i[2:0] == 3'h6 ? 5'h07 : 5'h04);
			chk("alu", 32'(alu_o), 32'(i[5:3]));
			chk("smem", 32'(src_mem_o), 32'(i[2:0] == 3'h6));
		end
		for (int i = 0; i < 8; i++) begin
			dec({2'h3, i[2:0], 3'h6}, 8'hff, OPD_CLS_ALU_IMM, 5'h07);
			chk("alu", 32'(alu_o), 32'(i[2:0]));
		end
	endtask
	task automatic t_pair();
		for (int p = 0; p < 4; p++) begin
			dec({2'h0, p[1:0], 4'h1}, 8'h00, OPD_CLS_LOAD_PAIR_IMMEDIATE, 5'h0a);
			chk("pair", 32'(pair_o), 32'(p[1:0]));
			dec({2'h0, p[1:0], 4'h3}, 8'h00, OPD_CLS_PAIR_INCREMENT, 5'h06);
			dec({2'h0, p[1:0], 4'hb}, 8'h00, OPD_CLS_PAIR_DECREMENT, 5'h06);
			dec({2'h0, p[1:0], 4'h9}, 8'h00, OPD_CLS_PAIR_ADD_TO_HL, 5'h0a);
			dec({2'h3, p[1:0], 4'h5}, 8'h00, OPD_CLS_PUSH, 5'h0c);
			chk("afw", 32'(accumulator_flags_word_o), 32'(p == 3));
			dec({2'h3, p[1:0], 4'h1}, 8'h00, OPD_CLS_POP, 5'h0a);
			chk("afw", 32'(accumulator_flags_word_o), 32'(p == 3));
		end
	endtask
	task automatic t_cond();
		// flag bit for zero, carry, parity, sign in condition-code order
		int         pos[4] = '{6, 0, 2, 7};
		logic [7:0] fl;
		logic       b;
		for (int j = 0; j < 5; j++) begin
			for (int cc = 0; cc < 8; cc++) begin
				fl = (j < 4) ? 8'h01 << pos[j] : 8'h00;
				b = fl[pos[cc[2:1]]] == cc[0];
				dec({2'h3, cc[2:0], 3'h2}, fl, OPD_CLS_COND_JUMP, b ? 5'h0a : 5'h07);
				chk("cond", 32'(cond_o), 32'(cc[2:0]));
				chk("true", 32'(cond_true_o), 32'(b));
				dec({2'h3, cc[2:0], 3'h4}, fl, OPD_CLS_COND_CALL, b ? 5'h12 : 5'h09);
				dec({2'h3, cc[2:0], 3'h0}, fl, OPD_CLS_COND_RET, b ? 5'h0c : 5'h06);
			end
		end
	endtask
	task automatic t_misc();
		dec(8'h0f, 8'h00, OPD_CLS_ROTATE_RIGHT_OP, 5'h04);
		dec(8'h17, 8'h00, OPD_CLS_ROTATE_LEFT_CARRY_OP, 5'h04);
		dec(8'h1f, 8'h00, OPD_CLS_ROTATE_RIGHT_CARRY_OP, 5'h04);
		dec(8'hc3, 8'h00, OPD_CLS_NONE, 5'h00);
		// back to back: rotate then swap on adjacent edges
		@(posedge clk_sys_i);
		op_valid_i <= 1'b1;
		opcode_i <= 8'h07;
		@(posedge clk_sys_i);
		opcode_i <= 8'he3;
		#1 chk("class", 32'(class_o), 32'(OPD_CLS_ROTATE_LEFT_OP));
		@(posedge clk_sys_i);
		op_valid_i <= 1'b0;
		#1 chk("class", 32'(class_o), 32'(OPD_CLS_SWAP_STACK_TOP_HL));
		chk("valid", 32'(dec_valid_o), 32'h1);
		@(posedge clk_sys_i);
		#1 chk("valid", 32'(dec_valid_o), 32'h0);
		chk("cycles", 32'(cycles_o), 32'h10);
		exp_total += 20;
	endtask
	task automatic t_reset();
		chk("total", 32'(total), 32'(exp_total));
		go(8'hf5, 8'h00);
		@(posedge clk_sys_i);
		resetn_i <= 1'b0;
		@(posedge clk_sys_i);
		resetn_i <= 1'b1;
		#1 t_clear();
		chk("total", 32'(total), 32'h0);
	endtask
	// ********************************
	// clock, sequence, verdict
	// ********************************
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		// about 590 cycles are needed; a hang trips long before the run grows
		repeat (5000) @(posedge clk_sys_i);
		bad_count++;
		final_report();
	end
	initial begin
		resetn_i = 1'b0;
		op_valid_i = 1'b0;
		opcode_i = 8'h00;
		flags_i = 8'h00;
		repeat (8) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		#1 t_clear();
		t_move();
		t_alu();
		t_pair();
		t_cond();
		t_misc();
		t_reset();
		final_report();
	end
endmodule

// File: core/opd_cycle_count.sv
// condition evaluation and clock-cycle count per class
`timescale 1ns/1ps
module opd_cycle_count (
	input  wire logic [7:0] flags_i,
	opd_dec_if.timer        dec
);
	import opd_pkg::*;

	function automatic logic cond_eval(input opd_cond_t c, input logic [7:0] f);
		logic r;
		r = 1'b0;
		case (c)
			OPD_CC_NOT_ZERO:   r = ~f[OPD_FLAG_Z];
			OPD_CC_ZERO:       r =  f[OPD_FLAG_Z];
			OPD_CC_NO_CARRY:   r = ~f[OPD_FLAG_CY];
			OPD_CC_CARRY:      r =  f[OPD_FLAG_CY];
			OPD_CC_PARITY_ODD: r = ~f[OPD_FLAG_P];
			OPD_CC_PARITY_EVEN:r =  f[OPD_FLAG_P];
			OPD_CC_POSITIVE:   r = ~f[OPD_FLAG_S];
			OPD_CC_MINUS:      r =  f[OPD_FLAG_S];
			default:           r = 1'b0;
		endcase
		return r;
	endfunction

	always_comb begin
		dec.cond_true = cond_eval(dec.cond, flags_i);
		case (dec.cls)
			OPD_CLS_COPY_OP:             dec.cycles = OPD_CYC_COPY;
			OPD_CLS_STORE_MEM,
			OPD_CLS_LOAD_MEM:            dec.cycles = OPD_CYC_MEM;
			OPD_CLS_HALT_OP:             dec.cycles = OPD_CYC_HALT;
			OPD_CLS_LOAD_PAIR_IMMEDIATE: dec.cycles = OPD_CYC_LDPAIR;
			OPD_CLS_PUSH:                dec.cycles = OPD_CYC_PUSH;
			OPD_CLS_POP:                 dec.cycles = OPD_CYC_POP;
			OPD_CLS_SWAP_STACK_TOP_HL:   dec.cycles = OPD_CYC_SWAP;
			OPD_CLS_COND_JUMP:           dec.cycles = dec.cond_true ? OPD_CYC_JMP_T : OPD_CYC_JMP_NT;
			OPD_CLS_COND_CALL:           dec.cycles = dec.cond_true ? OPD_CYC_CALL_T : OPD_CYC_CALL_NT;
			OPD_CLS_COND_RET:            dec.cycles = dec.cond_true ? OPD_CYC_RET_T : OPD_CYC_RET_NT;
			OPD_CLS_ALU_REG:             dec.cycles = OPD_CYC_ALU;
			OPD_CLS_ALU_MEM,
			OPD_CLS_ALU_IMM:             dec.cycles = OPD_CYC_MEM;
			OPD_CLS_PAIR_INCREMENT,
			OPD_CLS_PAIR_DECREMENT:      dec.cycles = OPD_CYC_PAIRID;
			OPD_CLS_PAIR_ADD_TO_HL:      dec.cycles = OPD_CYC_ADDHL;
			OPD_CLS_ROTATE_LEFT_OP,
			OPD_CLS_ROTATE_RIGHT_OP,
			OPD_CLS_ROTATE_LEFT_CARRY_OP,
			OPD_CLS_ROTATE_RIGHT_CARRY_OP: dec.cycles = OPD_CYC_ROT;
			default:                     dec.cycles = 5'h00;
		endcase
	end
endmodule

// File: core/opd_dec_if.sv
// interface carrying decoded fields between decoder modules
`timescale 1ns/1ps
interface opd_dec_if;
	import opd_pkg::*;
	opd_class_t cls;
	logic [2:0] dest_field;
	logic [2:0] src_field;
	logic [1:0] pair;
	opd_cond_t  cond;
	opd_alu_t   alu;
	logic       pair_is_accumulator_flags_word;
	logic       cond_true;
	logic [4:0] cycles;

	modport producer (output cls, dest_field, src_field, pair, cond, alu, pair_is_accumulator_flags_word);
	modport timer    (input cls, cond, output cond_true, cycles);
	modport consumer (input cls, dest_field, src_field, pair, cond, alu, pair_is_accumulator_flags_word,
		cond_true, cycles);
endinterface

// File: core/opd_decoder.sv
// registered top of the processor opcode decoder
// ********************************
// Overview of operation
// - 01 dest src copies a register to a register in 4 cycles.
// - 01110 src stores a register to memory at the high/low pair, 7 cycles.
// - 01 dest 110 loads a register from memory at high/low pair, 7 cycles.
// - register codes B0 C1 D2 E3 H4 L5 memory6 accumulator7.
// - 00 pp 0001 loads 16-bit immediate into pair B/D/H/SP, 10 cycles.
// - 11 pp 0101 pushes a pair in 12 cycles; pair 11 is accumulator and flags.
// - 11 pp 0001 pops a pair in 10 cycles; pair 11 restores accumulator and flags.
// - 11100011 swaps stack top with high/low pair in 16 cycles.
// - bits 5:3 select nz, z, nc, c, po, pe, p, m conditions.
// - conditional jumps take 7 or 10 cycles, calls 9 or 18.
// - 11 ccc 000 conditional return takes 6 or 12 cycles.
// - 10 op src applies one of eight ALU operations in 4 cycles.
// - 10 op 110 applies the ALU operation to memory in 7 cycles.
// - 11 op 110 applies the ALU operation to the immediate byte, 7 cycles.
// - 00 pp 0011 increments, 00 pp 1011 decrements a pair, 6 cycles.
// - 00 pp 1001 adds a pair to the high/low pair in 10 cycles.
// - rotates left, right, left through carry, right through carry, 4 cycles.
// ********************************
`timescale 1ns/1ps
module opd_decoder (
	input  wire logic                 clk_sys_i,
	input  wire logic                 resetn_i,
	input  wire logic                 op_valid_i,
	input  wire logic [7:0]           opcode_i,
	input  wire logic [7:0]           flags_i,
	output logic                      dec_valid_o,
	output opd_pkg::opd_class_t       class_o,
	output logic [2:0]                dest_field_o,
	output logic [2:0]                src_field_o,
	output logic [1:0]                pair_o,
	output opd_pkg::opd_cond_t        cond_o,
	output opd_pkg::opd_alu_t         alu_o,
	output logic                      accumulator_flags_word_o,
	output logic                      cond_true_o,
	output logic [4:0]                cycles_o,
	output logic                      dest_mem_o,
	output logic                      src_mem_o
);
	import opd_pkg::*;

	opd_dec_if dec ();

	opd_field_decode u_field (
		.opcode_i (opcode_i),
		.dec      (dec.producer)
	);

	opd_cycle_count u_cycle (
		.flags_i (flags_i),
		.dec     (dec.timer)
	);

	// ********************************
	// output registers
	// ********************************
	logic       next_valid;
	opd_class_t next_class;
	logic [2:0] next_dest;
	logic [2:0] next_src;
	logic [1:0] next_pair;
	opd_cond_t  next_cond;
	opd_alu_t   next_alu;
	logic       next_afw;
	logic       next_ct;
	logic [4:0] next_cycles;
	logic       next_dmem;
	logic       next_smem;

	// fields hold their last value when no opcode arrives
	always_comb begin
		next_valid  = op_valid_i;
		next_class  = class_o;
		next_dest   = dest_field_o;
		next_src    = src_field_o;
		next_pair   = pair_o;
		next_cond   = cond_o;
		next_alu    = alu_o;
		next_afw    = accumulator_flags_word_o;
		next_ct     = cond_true_o;
		next_cycles = cycles_o;
		next_dmem   = dest_mem_o;
		next_smem   = src_mem_o;
		if (op_valid_i) begin
			next_class  = dec.cls;
			next_dest   = dec.dest_field;
			next_src    = dec.src_field;
			next_pair   = dec.pair;
			next_cond   = dec.cond;
			next_alu    = dec.alu;
			next_afw    = dec.pair_is_accumulator_flags_word;
			next_ct     = dec.cond_true;
			next_cycles = dec.cycles;
			next_dmem   = (dec.cls == OPD_CLS_STORE_MEM);
			next_smem   = (dec.cls == OPD_CLS_LOAD_MEM) || (dec.cls == OPD_CLS_ALU_MEM);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			dec_valid_o              <= 1'b0;
			class_o                  <= OPD_CLS_NONE;
			dest_field_o             <= OPD_REG_B;
			src_field_o              <= OPD_REG_B;
			pair_o                   <= 2'h0;
			cond_o                   <= OPD_CC_NOT_ZERO;
			alu_o                    <= OPD_ALU_ADD;
			accumulator_flags_word_o <= 1'b0;
			cond_true_o              <= 1'b0;
			cycles_o                 <= 5'h00;
			dest_mem_o               <= 1'b0;
			src_mem_o                <= 1'b0;
		end else begin
			dec_valid_o              <= next_valid;
			class_o                  <= next_class;
			dest_field_o             <= next_dest;
			src_field_o              <= next_src;
			pair_o                   <= next_pair;
			cond_o                   <= next_cond;
			alu_o                    <= next_alu;
			accumulator_flags_word_o <= next_afw;
			cond_true_o              <= next_ct;
			cycles_o                 <= next_cycles;
			dest_mem_o               <= next_dmem;
			src_mem_o                <= next_smem;
		end
	end
endmodule

// File: core/opd_field_decode.sv
// combinational opcode classifier and field extractor
`timescale 1ns/1ps
module opd_field_decode (
	input  wire logic [7:0] opcode_i,
	opd_dec_if.producer     dec
);
	import opd_pkg::*;

	logic [1:0] grp;
	logic [2:0] lo3;
	logic [3:0] lo4;

	always_comb begin
		grp = opcode_i[7:6];
		lo3 = opcode_i[2:0];
		lo4 = opcode_i[3:0];
		dec.dest_field = opcode_i[OPD_DST_LSB +: OPD_REG_W];
		dec.src_field  = opcode_i[OPD_SRC_LSB +: OPD_REG_W];
		dec.pair       = opcode_i[OPD_PAIR_LSB +: OPD_PAIR_W];
		dec.cond       = opd_cond_t'(opcode_i[OPD_DST_LSB +: OPD_REG_W]);
		dec.alu        = opd_alu_t'(opcode_i[OPD_DST_LSB +: OPD_REG_W]);
		dec.cls        = OPD_CLS_NONE;
		if (opcode_i == OPD_HALT_OP) begin
			dec.cls = OPD_CLS_HALT_OP;
		end else begin
			case (grp)
				OPD_GRP_MOVE: begin
					if (dec.dest_field == OPD_REG_MEM)
						dec.cls = OPD_CLS_STORE_MEM;
					else if (dec.src_field == OPD_REG_MEM)
						dec.cls = OPD_CLS_LOAD_MEM;
					else
						dec.cls = OPD_CLS_COPY_OP;
				end
				OPD_GRP_ALU: begin
					dec.cls = (dec.src_field == OPD_REG_MEM) ? OPD_CLS_ALU_MEM : OPD_CLS_ALU_REG;
				end
				OPD_GRP_00: begin
					case (opcode_i)
						OPD_ROT_L:  dec.cls = OPD_CLS_ROTATE_LEFT_OP;
						OPD_ROT_R:  dec.cls = OPD_CLS_ROTATE_RIGHT_OP;
						OPD_ROT_LC: dec.cls = OPD_CLS_ROTATE_LEFT_CARRY_OP;
						OPD_ROT_RC: dec.cls = OPD_CLS_ROTATE_RIGHT_CARRY_OP;
						default: begin
							case (lo4)
								OPD_LO_LDPAIR: dec.cls = OPD_CLS_LOAD_PAIR_IMMEDIATE;
								OPD_LO_INC:    dec.cls = OPD_CLS_PAIR_INCREMENT;
								OPD_LO_DEC:    dec.cls = OPD_CLS_PAIR_DECREMENT;
								OPD_LO_ADDHL:  dec.cls = OPD_CLS_PAIR_ADD_TO_HL;
								default:       dec.cls = OPD_CLS_NONE;
							endcase
						end
					endcase
				end
				default: begin
					if (opcode_i == OPD_SWAP_OP)
						dec.cls = OPD_CLS_SWAP_STACK_TOP_HL;
					else if (lo4 == OPD_LO_PUSH)
						dec.cls = OPD_CLS_PUSH;
					else if (lo4 == OPD_LO_POP)
						dec.cls = OPD_CLS_POP;
					else begin
						case (lo3)
							OPD_LO3_RET:  dec.cls = OPD_CLS_COND_RET;
							OPD_LO3_JMP:  dec.cls = OPD_CLS_COND_JUMP;
							OPD_LO3_CALL: dec.cls = OPD_CLS_COND_CALL;
							OPD_LO3_IMM:  dec.cls = OPD_CLS_ALU_IMM;
							default:      dec.cls = OPD_CLS_NONE;
						endcase
					end
				end
			endcase
		end
		dec.pair_is_accumulator_flags_word = (dec.cls == OPD_CLS_PUSH || dec.cls == OPD_CLS_POP)
			&& dec.pair == OPD_PAIR_SP;
	end
endmodule

// File: core/opd_pkg.sv
// package of opcode decoder constants and types
package opd_pkg;

	// ********************************
	// field positions and widths
	// ********************************
	localparam int OPD_OP_W     = 8;
	localparam int OPD_REG_W    = 3;
	localparam int OPD_PAIR_W   = 2;
	localparam int OPD_CYC_W    = 5;
	localparam int OPD_DST_LSB  = 3;
	localparam int OPD_SRC_LSB  = 0;
	localparam int OPD_PAIR_LSB = 4;

	// ********************************
	// register and pair codes
	// ********************************
	localparam logic [2:0] OPD_REG_B   = 3'h0;
	localparam logic [2:0] OPD_REG_C   = 3'h1;
	localparam logic [2:0] OPD_REG_D   = 3'h2;
	localparam logic [2:0] OPD_REG_E   = 3'h3;
	localparam logic [2:0] OPD_REG_H   = 3'h4;
	localparam logic [2:0] OPD_REG_L   = 3'h5;
	localparam logic [2:0] OPD_REG_MEM = 3'h6;
	localparam logic [2:0] OPD_REG_A   = 3'h7;
	localparam logic [1:0] OPD_PAIR_SP = 2'h3;

	// ********************************
	// opcode patterns
	// ********************************
	localparam logic [7:0] OPD_HALT_OP     = 8'h76;
	localparam logic [7:0] OPD_SWAP_OP     = 8'he3;
	localparam logic [7:0] OPD_ROT_L       = 8'h07;
	localparam logic [7:0] OPD_ROT_R       = 8'h0f;
	localparam logic [7:0] OPD_ROT_LC      = 8'h17;
	localparam logic [7:0] OPD_ROT_RC      = 8'h1f;
	localparam logic [1:0] OPD_GRP_00      = 2'h0;
	localparam logic [1:0] OPD_GRP_MOVE    = 2'h1;
	localparam logic [1:0] OPD_GRP_ALU     = 2'h2;
	localparam logic [1:0] OPD_GRP_11      = 2'h3;
	localparam logic [3:0] OPD_LO_LDPAIR   = 4'h1;
	localparam logic [3:0] OPD_LO_INC      = 4'h3;
	localparam logic [3:0] OPD_LO_DEC      = 4'hb;
	localparam logic [3:0] OPD_LO_ADDHL    = 4'h9;
	localparam logic [3:0] OPD_LO_PUSH     = 4'h5;
	localparam logic [3:0] OPD_LO_POP      = 4'h1;
	localparam logic [2:0] OPD_LO3_RET     = 3'h0;
	localparam logic [2:0] OPD_LO3_JMP     = 3'h2;
	localparam logic [2:0] OPD_LO3_CALL    = 3'h4;
	localparam logic [2:0] OPD_LO3_IMM     = 3'h6;

	// ********************************
	// cycle counts
	// ********************************
	localparam logic [4:0] OPD_CYC_COPY    = 5'h04;
	localparam logic [4:0] OPD_CYC_MEM     = 5'h07;
	localparam logic [4:0] OPD_CYC_HALT    = 5'h05;
	localparam logic [4:0] OPD_CYC_LDPAIR  = 5'h0a;
	localparam logic [4:0] OPD_CYC_PUSH    = 5'h0c;
	localparam logic [4:0] OPD_CYC_POP     = 5'h0a;
	localparam logic [4:0] OPD_CYC_SWAP    = 5'h10;
	localparam logic [4:0] OPD_CYC_JMP_NT  = 5'h07;
	localparam logic [4:0] OPD_CYC_JMP_T   = 5'h0a;
	localparam logic [4:0] OPD_CYC_CALL_NT = 5'h09;
	localparam logic [4:0] OPD_CYC_CALL_T  = 5'h12;
	localparam logic [4:0] OPD_CYC_RET_NT  = 5'h06;
	localparam logic [4:0] OPD_CYC_RET_T   = 5'h0c;
	localparam logic [4:0] OPD_CYC_ALU     = 5'h04;
	localparam logic [4:0] OPD_CYC_PAIRID  = 5'h06;
	localparam logic [4:0] OPD_CYC_ADDHL   = 5'h0a;
	localparam logic [4:0] OPD_CYC_ROT     = 5'h04;

	// ********************************
	// flag word bits
	// ********************************
	localparam int OPD_FLAG_CY = 0;
	localparam int OPD_FLAG_P  = 2;
	localparam int OPD_FLAG_Z  = 6;
	localparam int OPD_FLAG_S  = 7;

	typedef enum logic [4:0] {
		OPD_CLS_NONE,
		OPD_CLS_COPY_OP,
		OPD_CLS_STORE_MEM,
		OPD_CLS_LOAD_MEM,
		OPD_CLS_HALT_OP,
		OPD_CLS_LOAD_PAIR_IMMEDIATE,
		OPD_CLS_PUSH,
		OPD_CLS_POP,
		OPD_CLS_SWAP_STACK_TOP_HL,
		OPD_CLS_COND_JUMP,
		OPD_CLS_COND_CALL,
		OPD_CLS_COND_RET,
		OPD_CLS_ALU_REG,
		OPD_CLS_ALU_MEM,
		OPD_CLS_ALU_IMM,
		OPD_CLS_PAIR_INCREMENT,
		OPD_CLS_PAIR_DECREMENT,
		OPD_CLS_PAIR_ADD_TO_HL,
		OPD_CLS_ROTATE_LEFT_OP,
		OPD_CLS_ROTATE_RIGHT_OP,
		OPD_CLS_ROTATE_LEFT_CARRY_OP,
		OPD_CLS_ROTATE_RIGHT_CARRY_OP
	} opd_class_t;

	typedef enum logic [2:0] {
		OPD_ALU_ADD,
		OPD_ALU_ADD_CARRY,
		OPD_ALU_SUB,
		OPD_ALU_SUBTRACT_WITH_BORROW_OP,
		OPD_ALU_AND_OP,
		OPD_ALU_XOR_OP,
		OPD_ALU_OR_OP,
		OPD_ALU_COMPARE_OP
	} opd_alu_t;

	typedef enum logic [2:0] {
		OPD_CC_NOT_ZERO,
		OPD_CC_ZERO,
		OPD_CC_NO_CARRY,
		OPD_CC_CARRY,
		OPD_CC_PARITY_ODD,
		OPD_CC_PARITY_EVEN,
		OPD_CC_POSITIVE,
		OPD_CC_MINUS
	} opd_cond_t;

endpackage
